// ### src/dac_datapath_control_regs.sv
// dac datapath control registers, test-level substitution and tuning load
`timescale 1ns/1ps
`default_nettype none
`include "dac_consts.svh"

module dac_datapath_control_regs (
   // clock and reset
   input  wire logic               sys_clk,
   input  wire logic               resetn,
   // serial control port
   input  wire logic               spi_csn,
   input  wire logic               spi_sclk,
   input  wire logic               spi_sdi,
   output logic                    spi_sdo,
   output logic                    spi_sdo_oe,
   // sample streams
   input  wire logic [15:0]        sample_i,
   input  wire logic [15:0]        sample_q,
   output logic [15:0]             out_i,
   output logic [15:0]             out_q,
   // datapath controls
   output logic                    sinc_compensation_on,
   output logic                    gain_stage_on,
   output logic                    phase_compensation_on,
   output dac_regs_pkg::mod_sel_t  modulation,
   // working oscillator settings
   output logic [47:0]             tuning_word,
   output logic [15:0]             phase_offset
);

   logic [1:0]  rst_pipe_q;
   wire  logic  rst_n;
   wire  logic  rd_req;
   wire  logic  wr_req;
   wire  logic [14:0] addr;
   wire  logic [7:0]  wr_data;
   logic [7:0]  rd_data_q;
   logic [7:0]  test_q;
   logic [7:0]  dc_i_lo_q;
   logic [7:0]  dc_i_hi_q;
   logic [7:0]  dc_q_lo_q;
   logic [7:0]  dc_q_hi_q;
   logic [7:0]  enc_q;
   logic [7:0]  path_q;
   logic [7:0]  load_q;
   logic        done_q;
   logic [7:0]  tune_q [8];
   wire  logic [63:0] tune_flat;

   ////////////////////////////////////////////////////////////////////////////
   // reset release through two flops
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         rst_pipe_q <= 2'h0;
      else
         rst_pipe_q <= {rst_pipe_q[0], 1'b1};
   end
   assign rst_n = rst_pipe_q[1];

   // serial access to the register bank
   serial_port u_port (
      .clk     (sys_clk),
      .rst_n   (rst_n),
      .csn     (spi_csn),
      .sclk    (spi_sclk),
      .sdi     (spi_sdi),
      .sdo     (spi_sdo),
      .sdo_oe  (spi_sdo_oe),
      .rd_data (rd_data_q),
      .rd_req  (rd_req),
      .wr_req  (wr_req),
      .addr    (addr),
      .wr_data (wr_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // address decode
   wire logic [14:0] tune_off = addr - `ADDR_TUNE_BASE;
   wire logic tune_hit  = (tune_off < `TUNE_BYTES);
   wire logic wr_test   = wr_req && addr == `ADDR_TEST_CTRL;
   wire logic wr_i_lo   = wr_req && addr == `ADDR_DC_I_LOW;
   wire logic wr_i_hi   = wr_req && addr == `ADDR_DC_I_HIGH;
   wire logic wr_q_lo   = wr_req && addr == `ADDR_DC_Q_LOW;
   wire logic wr_q_hi   = wr_req && addr == `ADDR_DC_Q_HIGH;
   wire logic wr_enc    = wr_req && addr == `ADDR_ENCODING;
   wire logic wr_path   = wr_req && addr == `ADDR_PATH_CTRL;
   wire logic wr_load   = wr_req && addr == `ADDR_TUNE_LOAD;
   // request bit going from clear to set starts a load
   wire logic load_rise = wr_load && wr_data[`BIT_LOAD_REQ]
                          && !load_q[`BIT_LOAD_REQ];

   // readback mux; unmapped addresses read zero
   wire logic [7:0] load_rd = {load_q[7:2], done_q, load_q[`BIT_LOAD_REQ]};
   wire logic [7:0] rd_mux =
      (addr == `ADDR_TEST_CTRL) ? test_q    :
      (addr == `ADDR_DC_I_LOW)  ? dc_i_lo_q :
      (addr == `ADDR_DC_I_HIGH) ? dc_i_hi_q :
      (addr == `ADDR_DC_Q_LOW)  ? dc_q_lo_q :
      (addr == `ADDR_DC_Q_HIGH) ? dc_q_hi_q :
      (addr == `ADDR_ENCODING)  ? enc_q     :
      (addr == `ADDR_PATH_CTRL) ? path_q    :
      (addr == `ADDR_TUNE_LOAD) ? load_rd   :
      tune_hit                  ? tune_q[tune_off[2:0]] : 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // byte registers
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         test_q    <= `RST_TEST_CTRL;
         dc_i_lo_q <= `RST_DC_BYTE;
         dc_i_hi_q <= `RST_DC_BYTE;
         dc_q_lo_q <= `RST_DC_BYTE;
         dc_q_hi_q <= `RST_DC_BYTE;
         enc_q     <= `RST_ENCODING;
         path_q    <= `RST_PATH_CTRL;
         load_q    <= `RST_TUNE_LOAD;
         rd_data_q <= 8'h00;
      end
      else
      begin
         if (wr_test) test_q    <= wr_data;
         if (wr_i_lo) dc_i_lo_q <= wr_data;
         if (wr_i_hi) dc_i_hi_q <= wr_data;
         if (wr_q_lo) dc_q_lo_q <= wr_data;
         if (wr_q_hi) dc_q_hi_q <= wr_data;
         if (wr_enc)  enc_q     <= wr_data;
         if (wr_path) path_q    <= wr_data;
         if (wr_load) load_q    <= wr_data;
         if (rd_req)  rd_data_q <= rd_mux;
      end
   end

   // tuning shadow bytes, not used until a load
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1)
      begin : g_tune
         always_ff @(posedge sys_clk or negedge rst_n)
         begin
            if (!rst_n)
               tune_q[g] <= 8'h00;
            else if (wr_req && tune_hit && tune_off[2:0] == 3'(g))
               tune_q[g] <= wr_data;
         end
         assign tune_flat[g*8 +: 8] = tune_q[g];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // working oscillator state and load acknowledge; a load beats a clear
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tuning_word  <= 48'h000000000000;
         phase_offset <= 16'h0000;
         done_q       <= 1'b0;
      end
      else if (load_rise)
      begin
         tuning_word  <= tune_flat[47:0];
         phase_offset <= tune_flat[63:48];
         done_q       <= 1'b1;
      end
      else if (wr_load && !wr_data[`BIT_LOAD_REQ])
         done_q <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // datapath controls and sample substitution
   wire logic test_en = test_q[`BIT_TEST_EN];
   wire logic offset_bin = enc_q[`BIT_OFFSET_BIN];
   // offset binary becomes twos complement by flipping the sign bit
   wire logic [15:0] conv_i = {sample_i[15] ^ offset_bin, sample_i[14:0]};
   wire logic [15:0] conv_q = {sample_q[15] ^ offset_bin, sample_q[14:0]};

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         out_i                 <= 16'h0000;
         out_q                 <= 16'h0000;
         sinc_compensation_on  <= 1'b0;
         gain_stage_on         <= 1'b1;
         phase_compensation_on <= 1'b0;
         modulation            <= dac_regs_pkg::MOD_NONE;
      end
      else
      begin
         out_i <= test_en ? {dc_i_hi_q, dc_i_lo_q} : conv_i;
         out_q <= test_en ? {dc_q_hi_q, dc_q_lo_q} : conv_q;
         sinc_compensation_on  <= path_q[`BIT_SINC_ON];
         gain_stage_on         <= path_q[`BIT_GAIN_ON];
         phase_compensation_on <= path_q[`BIT_PHASE_ON];
         modulation <= dac_regs_pkg::mod_sel_t'(
                       path_q[`FLD_MOD_HI:`FLD_MOD_LO]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence load_start;
      wr_load && wr_data[`BIT_LOAD_REQ] && !load_q[`BIT_LOAD_REQ];
   endsequence
   sequence load_taken;
      tuning_word == $past(tune_flat[47:0]) && done_q
      && phase_offset == $past(tune_flat[63:48]);
   endsequence

   i_high_wr_a: assert property (
      wr_i_hi |=> dc_i_hi_q == $past(wr_data))
      else $error("I upper byte not written");
   q_level_wr_a: assert property (
      wr_q_lo ##2 !wr_req && test_en |=> out_q[7:0] == $past(dc_q_lo_q))
      else $error("Q lower byte not used");
   encode_conv_a: assert property (
      !test_en && offset_bin
      |=> out_i == {~$past(sample_i[15]), $past(sample_i[14:0])})
      else $error("offset binary not converted");
   sinc_follow_a: assert property (
      sinc_compensation_on == $past(path_q[`BIT_SINC_ON]) || $rose(rst_n))
      else $error("sinc enable mismatch");
   gain_follow_a: assert property (
      gain_stage_on == $past(path_q[`BIT_GAIN_ON]) || $rose(rst_n))
      else $error("gain enable mismatch");
   phase_follow_a: assert property (
      wr_path ##2 1'b1
      |-> phase_compensation_on == $past(wr_data[`BIT_PHASE_ON], 2))
      else $error("phase enable mismatch");
   mod_select_a: assert property (
      wr_path |-> ##2
      modulation == $past(wr_data[`FLD_MOD_HI:`FLD_MOD_LO], 2))
      else $error("modulation select mismatch");
   i_low_wr_a: assert property (
      wr_i_lo |=> dc_i_lo_q == $past(wr_data))
      else $error("I lower byte not written");
   tune_load_a: assert property (load_start |=> load_taken)
      else $error("tuning load missing");
   tune_hold_a: assert property (!load_rise |=> $stable(tuning_word))
      else $error("tuning word moved without load");
   dc_subst_a: assert property (
      test_en |=> out_i == {$past(dc_i_hi_q), $past(dc_i_lo_q)})
      else $error("I test level not substituted");

endmodule
`default_nettype wire

// ### inc/dac_consts.svh
// offsets, field positions, reset values and port timing for the dac control bank
// How it works
// - I level upper byte, read/write, resets zero
// - Q level in two bytes, both reset zero
// - encoding bit: clear twos complement, set offset
// - sinc filter used only while its bit set
// - gain stage bit five, comes out set
// - phase compensation only while bit four set
// - two-bit modulation select, resets to none
// - I level lower byte below upper, resets zero
// - tuning values load only on request rising edge
`ifndef DAC_CONSTS_SVH
`define DAC_CONSTS_SVH

// register addresses on the serial control port
`define ADDR_TEST_CTRL  15'h00F7
`define ADDR_DC_I_LOW   15'h00F8
`define ADDR_DC_I_HIGH  15'h00F9
`define ADDR_DC_Q_LOW   15'h00FA
`define ADDR_DC_Q_HIGH  15'h00FB
`define ADDR_ENCODING   15'h0110
`define ADDR_PATH_CTRL  15'h0111
`define ADDR_TUNE_LOAD  15'h0113
`define ADDR_TUNE_BASE  15'h0114
`define TUNE_BYTES      15'h0008

// field positions
`define BIT_TEST_EN     1
`define BIT_OFFSET_BIN  7
`define BIT_SINC_ON     7
`define BIT_GAIN_ON     5
`define BIT_PHASE_ON    4
`define FLD_MOD_HI      3
`define FLD_MOD_LO      2
`define BIT_LOAD_REQ    0
`define BIT_LOAD_DONE   1

// reset values
`define RST_TEST_CTRL   8'h00
`define RST_DC_BYTE     8'h00
`define RST_ENCODING    8'h00
`define RST_PATH_CTRL   8'h20
`define RST_TUNE_LOAD   8'h00

// serial frame: read flag, 15-bit address, then one data byte
`define INSTR_BITS      4'hF
`define DATA_BITS       4'h7

`endif

// ### inc/dac_regs_pkg.sv
// types shared by the dac control bank and its serial port
package dac_regs_pkg;

   // modulation selected for the datapath
   typedef enum logic [1:0] {
      MOD_NONE   = 2'h0,
      MOD_FINE   = 2'h1,
      MOD_QUART  = 2'h2,
      MOD_EIGHTH = 2'h3
   } mod_sel_t;

   // serial port frame phase
   typedef enum logic [2:0] {
      SP_INSTR = 3'h1,
      SP_DATA  = 3'h2,
      SP_DONE  = 3'h4
   } serial_state_t;

endpackage

// ### src/serial_port.sv
// serial control port slave: one instruction and one data byte per frame
`timescale 1ns/1ps
`default_nettype none
`include "dac_consts.svh"

module serial_port (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // serial pins
   input  wire logic        csn,
   input  wire logic        sclk,
   input  wire logic        sdi,
   output logic             sdo,
   output logic             sdo_oe,
   // register access
   input  wire logic [7:0]  rd_data,
   output logic             rd_req,
   output logic             wr_req,
   output logic [14:0]      addr,
   output logic [7:0]       wr_data
);

   dac_regs_pkg::serial_state_t state_q;
   logic        sclk_q;
   logic [15:0] shift_q;
   logic [3:0]  cnt_q;
   logic        rnw_q;
   logic [7:0]  tx_q;
   wire  logic  rise;
   wire  logic  fall;
   wire  logic  tx_first;

   // edges of the serial clock, seen in the system clock
   assign rise     = sclk & ~sclk_q;
   assign fall     = ~sclk & sclk_q;
   assign tx_first = (cnt_q == 4'h0);

   ////////////////////////////////////////////////////////////////////////////
   // receive: shift in on rising edges, decode instruction then data
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= dac_regs_pkg::SP_INSTR;
         sclk_q  <= 1'b0;
         shift_q <= 16'h0000;
         cnt_q   <= 4'h0;
         rnw_q   <= 1'b0;
         rd_req  <= 1'b0;
         wr_req  <= 1'b0;
         addr    <= 15'h0000;
         wr_data <= 8'h00;
      end
      else
      begin
         sclk_q <= sclk;
         rd_req <= 1'b0;
         wr_req <= 1'b0;
         if (csn)
         begin
            state_q <= dac_regs_pkg::SP_INSTR;
            cnt_q   <= 4'h0;
         end
         else if (rise)
         begin
            shift_q <= {shift_q[14:0], sdi};
            cnt_q   <= cnt_q + 4'h1;
            unique case (state_q)
               dac_regs_pkg::SP_INSTR:
                  if (cnt_q == `INSTR_BITS)
                  begin
                     rnw_q   <= shift_q[14];
                     addr    <= {shift_q[13:0], sdi};
                     rd_req  <= shift_q[14];
                     state_q <= dac_regs_pkg::SP_DATA;
                  end
               dac_regs_pkg::SP_DATA:
                  if (cnt_q == `DATA_BITS)
                  begin
                     wr_req  <= ~rnw_q;
                     wr_data <= {shift_q[6:0], sdi};
                     state_q <= dac_regs_pkg::SP_DONE;
                  end
               dac_regs_pkg::SP_DONE:
                  state_q <= dac_regs_pkg::SP_DONE; // extra bits ignored
               default:
                  state_q <= dac_regs_pkg::SP_INSTR;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmit: read data leaves msb first on falling edges
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sdo    <= 1'b0;
         sdo_oe <= 1'b0;
         tx_q   <= 8'h00;
      end
      else if (csn)
         sdo_oe <= 1'b0;
      else if (fall && rnw_q && state_q == dac_regs_pkg::SP_DATA)
      begin
         sdo_oe <= 1'b1;
         sdo    <= tx_first ? rd_data[7] : tx_q[7];
         tx_q   <= tx_first ? {rd_data[6:0], 1'b0} : {tx_q[6:0], 1'b0};
      end
   end

endmodule
`default_nettype wire

// ### verif/testbench.sv
// self-checking testbench for the dac datapath control bank
`timescale 1ns/1ps
`default_nettype none
`include "dac_consts.svh"

module testbench;
   logic                   sys_clk;
   logic                   resetn;
   logic                   spi_csn;
   logic                   spi_sclk;
   logic                   spi_sdi;
   logic                   spi_sdo;
   logic                   spi_sdo_oe;
   logic [15:0]            sample_i;
   logic [15:0]            sample_q;
   logic [15:0]            out_i;
   logic [15:0]            out_q;
   logic                   sinc_compensation_on;
   logic                   gain_stage_on;
   logic                   phase_compensation_on;
   dac_regs_pkg::mod_sel_t modulation;
   logic [47:0]            tuning_word;
   logic [15:0]            phase_offset;
   int                     errors;
   int                     checked;
   logic [7:0]             rd_v;
   logic                   oe_v;
   logic [7:0]             path_tab [4];

   dac_datapath_control_regs i_dut (
      .sys_clk               (sys_clk),
      .resetn                (resetn),
      .spi_csn               (spi_csn),
      .spi_sclk              (spi_sclk),
      .spi_sdi               (spi_sdi),
      .spi_sdo               (spi_sdo),
      .spi_sdo_oe            (spi_sdo_oe),
      .sample_i              (sample_i),
      .sample_q              (sample_q),
      .out_i                 (out_i),
      .out_q                 (out_q),
      .sinc_compensation_on  (sinc_compensation_on),
      .gain_stage_on         (gain_stage_on),
      .phase_compensation_on (phase_compensation_on),
      .modulation            (modulation),
      .tuning_word           (tuning_word),
      .phase_offset          (phase_offset)
   );

   ////////////////////////////////////////////////////////////////////////
   // 200 MHz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   // compare and count
   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch at %0t: seen 0x%0h expected 0x%0h",
                  $time, seen, exp);
      end
   endtask

   // wait a number of falling edges
   task automatic idle(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   // one serial bit: low half with data set up, high half, sample sdo
   task automatic sbit(input logic b, output logic s);
      spi_sclk = 1'b0;
      spi_sdi  = b;
      idle(4);
      spi_sclk = 1'b1;
      idle(4);
      s = spi_sdo;
   endtask

   // one frame: read flag, 15-bit address, one data byte
   task automatic xfer(input logic rd, input logic [14:0] a,
                       input logic [7:0] wd, output logic [7:0] rv);
      logic [23:0] frame;
      logic        s;
      frame   = {rd, a, wd};
      rv      = 8'h00;
      spi_csn = 1'b0;
      idle(2);
      for (int k = 23; k >= 0; k--)
      begin
         sbit(frame[k], s);
         if (k < 8)
            rv[k] = s;
         if (k == 0)
            oe_v = spi_sdo_oe; // driver state during the last data bit
      end
      spi_sclk = 1'b0;
      idle(4);
      spi_csn = 1'b1;
      idle(6);
   endtask

   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      xfer(1'b0, a, d, rd_v);
      chk(oe_v, 1'b0);
   endtask

   task automatic rdchk(input logic [14:0] a, input logic [7:0] exp);
      xfer(1'b1, a, 8'h00, rd_v);
      chk(rd_v, exp);
      chk(oe_v, 1'b1);
      chk(spi_sdo_oe, 1'b0);
   endtask

   // verdict and end of run
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // watchdog well beyond the expected ten thousand cycles
   initial
   begin
      repeat (40000) @(posedge sys_clk);
      errors++;
      complete_run();
   end

   // main sequence
   initial
   begin
      errors   = 0;
      checked  = 0;
      resetn   = 1'b0;
      spi_csn  = 1'b1;
      spi_sclk = 1'b0;
      spi_sdi  = 1'b0;
      sample_i = 16'h1234;
      sample_q = 16'h5678;
      path_tab = '{8'h80, 8'h14, 8'h28, 8'hBC};
      idle(20);
      resetn = 1'b1;
      idle(5);
      // reset values at ports and registers
      chk(gain_stage_on, 1'b1);
      chk(sinc_compensation_on, 1'b0);
      chk(phase_compensation_on, 1'b0);
      chk(modulation, dac_regs_pkg::MOD_NONE);
      chk(out_i, 16'h1234);
      rdchk(`ADDR_DC_I_LOW, 8'h00);
      rdchk(`ADDR_DC_I_HIGH, 8'h00);
      rdchk(`ADDR_DC_Q_LOW, 8'h00);
      rdchk(`ADDR_DC_Q_HIGH, 8'h00);
      rdchk(`ADDR_ENCODING, 8'h00);
      rdchk(`ADDR_PATH_CTRL, 8'h20);
      $display("test reset values done");
      // constant level bytes written and read back, unmapped read is zero
      wr(`ADDR_DC_I_LOW, 8'hA5);
      wr(`ADDR_DC_I_HIGH, 8'h3C);
      wr(`ADDR_DC_Q_LOW, 8'hC3);
      wr(`ADDR_DC_Q_HIGH, 8'h5A);
      rdchk(`ADDR_DC_I_LOW, 8'hA5);
      rdchk(`ADDR_DC_I_HIGH, 8'h3C);
      rdchk(`ADDR_DC_Q_LOW, 8'hC3);
      rdchk(`ADDR_DC_Q_HIGH, 8'h5A);
      rdchk(15'h0100, 8'h00);
      $display("test level registers done");
      // test mode substitutes the assembled levels
      wr(`ADDR_TEST_CTRL, 8'h02);
      chk(out_i, 16'h3CA5);
      chk(out_q, 16'h5AC3);
      sample_i = 16'h0F0F;
      idle(3);
      chk(out_i, 16'h3CA5);
      wr(`ADDR_DC_Q_LOW, 8'h3E);
      chk(out_q, 16'h5A3E);
      wr(`ADDR_TEST_CTRL, 8'h00);
      chk(out_i, 16'h0F0F);
      $display("test constant output done");
      // sample encoding: offset binary has its msb inverted
      sample_i = 16'h8001;
      sample_q = 16'h7FFE;
      idle(3);
      chk(out_i, 16'h8001);
      wr(`ADDR_ENCODING, 8'h80);
      rdchk(`ADDR_ENCODING, 8'h80);
      chk(out_i, 16'h0001);
      chk(out_q, 16'hFFFE);
      wr(`ADDR_ENCODING, 8'h00);
      chk(out_i, 16'h8001);
      $display("test sample encoding done");
      // every modulation code with a mix of enables
      for (int i = 0; i < 4; i++)
      begin
         wr(`ADDR_PATH_CTRL, path_tab[i]);
         rdchk(`ADDR_PATH_CTRL, path_tab[i]);
         chk(sinc_compensation_on, path_tab[i][7]);
         chk(gain_stage_on, path_tab[i][5]);
         chk(phase_compensation_on, path_tab[i][4]);
         chk(modulation, path_tab[i][3:2]);
      end
      $display("test datapath control done");
      // tuning values load only on a rising request
      for (int k = 0; k < 8; k++)
         wr(`ADDR_TUNE_BASE + 15'(k), 8'((k + 1) * 17));
      chk(tuning_word, 48'h0);
      chk(phase_offset, 16'h0);
      rdchk(`ADDR_TUNE_LOAD, 8'h00);
      wr(`ADDR_TUNE_LOAD, 8'h01);
      chk(tuning_word, 48'h665544332211);
      chk(phase_offset, 16'h8877);
      rdchk(`ADDR_TUNE_LOAD, 8'h03);
      wr(`ADDR_TUNE_BASE, 8'hFF);
      wr(`ADDR_TUNE_LOAD, 8'h01);
      chk(tuning_word, 48'h665544332211);
      wr(`ADDR_TUNE_LOAD, 8'h00);
      rdchk(`ADDR_TUNE_LOAD, 8'h00);
      wr(`ADDR_TUNE_LOAD, 8'h01);
      chk(tuning_word, 48'h6655443322FF);
      $display("test tuning load done");
      complete_run();
   end
endmodule

`default_nettype wire
